// ===== core/pwt_pkg.sv
// Constants, register map and types for the PWM timer control block.
// Assumes a single bus and counter clock; no imports, names are scoped.
package pwt_pkg;
   // Printed register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL_A = 8'h00;
   localparam logic [7:0] IDX_CTRL_B_CLR = 8'h04;
   localparam logic [7:0] IDX_CTRL_B_SET = 8'h05;
   localparam logic [7:0] IDX_SYNC_FLAGS = 8'h08;
   localparam logic [7:0] IDX_COUNT_SNAP = 8'h0f;
   localparam logic [1:0] ADDR_SHIFT = 2'h2;
   // Control A fields
   localparam int CA_SOFT_RESET = 0;
   localparam int CA_ENABLE = 1;
   localparam int CA_RESOL_LO = 5;
   localparam int CA_PRESC_LO = 8;
   localparam int CA_STDBY = 11;
   // Control B fields
   localparam int CB_DIR = 0;
   localparam int CB_UPDATE_LOCK = 1;
   localparam int CB_SINGLE_RUN = 2;
   localparam int CB_IDX_LO = 3;
   localparam int CB_CMD_LO = 5;
   // Sync busy fields
   localparam int SB_SOFT_RESET = 0;
   localparam int SB_ENABLE = 1;
   // Crossing latency in cycles
   localparam logic [2:0] SYNC_CYCLES = 3'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_RETRIGGER = 3'h1,
      CMD_STOP = 3'h2,
      CMD_UPDATE = 3'h3,
      CMD_COUNT_READ_SYNC_CMD = 3'h4
   } pwt_cmd_t;

   typedef enum logic [1:0] {
      IDX_TOGGLE = 2'h0,
      IDX_FORCE_B = 2'h1,
      IDX_FORCE_A = 2'h2,
      IDX_HOLD = 2'h3
   } pwt_idx_t;

   typedef enum logic [1:0] {
      DITH_NONE = 2'h0,
      DITH_16 = 2'h1,
      DITH_32 = 2'h2,
      DITH_64 = 2'h3
   } pwt_dith_t;

   // Prescaler wrap masks for divide by 1..1024
   function automatic logic [9:0] presc_mask(input logic [2:0] code);
      case (code)
         3'h0: presc_mask = 10'h000;
         3'h1: presc_mask = 10'h001;
         3'h2: presc_mask = 10'h003;
         3'h3: presc_mask = 10'h007;
         3'h4: presc_mask = 10'h00f;
         3'h5: presc_mask = 10'h03f;
         3'h6: presc_mask = 10'h0ff;
         default: presc_mask = 10'h3ff;
      endcase
   endfunction

   // Dither frame masks for 16, 32, 64 frames
   function automatic logic [5:0] dith_mask(input logic [1:0] code);
      case (code)
         DITH_16: dith_mask = 6'h0f;
         DITH_32: dith_mask = 6'h1f;
         DITH_64: dith_mask = 6'h3f;
         default: dith_mask = 6'h00;
      endcase
   endfunction
endpackage

// ===== core/pwt_timer_ctrl.sv
// PWM timer control: control A, control B clear/set, sync flags, counter.
// Assumes an AXI4-Lite master on mclk and a counter on the same clock.
`timescale 1ns/1ps

// Functional notes
// - Standby halts counter unless standby-run set
// - Prescaler divides by 1 to 1024
// - Dither over 16/32/64 frames using low bits
// - Enable reads back at once, busy flag
// - Soft reset clears registers, disables counter
// - Soft reset discards rest of write
// - Reset bit reads one until done
// - Clear and set registers share state
// - Commands decode, run on prescaled tick
// - Zero writes idle; clear cancels pending
// - Ramp index command at dual-ramp update
// - Single run stops at wrap or stop
// - Clear register turns single run off
// - Lock blocks buffer copy on hardware update; update command still copies
// - Lock ignored while capture enabled
// - Clear register unlocks buffer updates
// - Direction bit; clear selects counting up
// - Set register sets bits and commands
// - Sync flags set at start, clear at end
module pwt_timer_ctrl #(
   parameter int CNT_W = 24
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic clkEn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic standbyMode,
   input wire logic captureEn,
   input wire logic dualRampMode,
   input wire logic [CNT_W-1:0] periodValue,
   output logic [CNT_W-1:0] count,
   output logic countDown,
   output logic counterRunning,
   output logic counterEnabled,
   output logic bufferCopy,
   output logic cycleIndexFlag,
   output logic ditherExtra
);

   typedef struct packed {
      logic standbyRun;
      logic [2:0] presc;
      logic [1:0] resol;
      logic enableReq;
      logic softReset;
      logic enActive;
      logic enBusy;
      logic rstBusy;
      logic [2:0] syncCnt;
      logic [2:0] cmd;
      logic [1:0] ramp_index_cmd;
      logic singleRun;
      logic updateLock;
      logic dirDown;
      logic [9:0] prescCnt;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] countSnap;
      logic running;
      logic cycleIdx;
      logic [5:0] frameCnt;
      logic bufCopy;
      logic dithExtra;
   } pwt_core_t;

   typedef struct packed {
      pwt_core_t core;
      logic awHeld;
      logic [7:0] awAddr;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } pwt_state_t;

   pwt_state_t s_r;
   pwt_state_t s_nxt;
   logic tick;
   logic wrap;
   logic updCond;
   logic doWrite;
   logic rstDone;
   logic [7:0] ctrlB;
   logic [5:0] dMask;

   // Handshakes only while clocked, so a frozen slave loses no transfer
   assign s_axi_awready = clkEn && !s_r.awHeld && !s_r.bValid;
   assign s_axi_wready = clkEn && !s_r.wHeld && !s_r.bValid;
   assign s_axi_arready = clkEn && !s_r.rValid;
   assign s_axi_bvalid = clkEn && s_r.bValid;
   assign s_axi_bresp = s_r.bResp;
   assign s_axi_rvalid = clkEn && s_r.rValid;
   assign s_axi_rdata = s_r.rData;
   assign s_axi_rresp = s_r.rResp;
   assign count = s_r.core.count;
   assign countDown = s_r.core.dirDown;
   assign counterRunning = s_r.core.running;
   assign counterEnabled = s_r.core.enActive;
   assign bufferCopy = s_r.core.bufCopy;
   assign cycleIndexFlag = s_r.core.cycleIdx;
   assign ditherExtra = s_r.core.dithExtra;

   // Shared view of control B for both addresses
   assign ctrlB = {s_r.core.cmd, s_r.core.ramp_index_cmd, s_r.core.singleRun,
      s_r.core.updateLock, s_r.core.dirDown};

   // Prescaled tick; frozen in standby unless allowed to run
   assign tick = s_r.core.enActive
      && (!standbyMode || s_r.core.standbyRun)
      && ((s_r.core.prescCnt & pwt_pkg::presc_mask(s_r.core.presc))
         == pwt_pkg::presc_mask(s_r.core.presc));
   assign wrap = s_r.core.dirDown ? (s_r.core.count == '0)
      : (s_r.core.count == periodValue);
   assign updCond = tick && s_r.core.running && wrap;
   assign doWrite = s_r.awHeld && s_r.wHeld && !s_r.bValid;
   assign rstDone = (s_r.core.enBusy || s_r.core.rstBusy)
      && (s_r.core.syncCnt == pwt_pkg::SYNC_CYCLES - 3'h1);
   assign dMask = pwt_pkg::dith_mask(s_r.core.resol);

   always_comb
   begin
      logic [7:0] idx;
      logic [7:0] wb;
      idx = s_r.awAddr >> pwt_pkg::ADDR_SHIFT;
      wb = s_r.wData[7:0];
      s_nxt = s_r;
      s_nxt.core.bufCopy = 1'b0;

      // Sync counter runs while any crossing is busy
      if (s_r.core.enBusy || s_r.core.rstBusy)
      begin
         s_nxt.core.syncCnt = s_r.core.syncCnt + 3'h1;
      end

      // Prescaler
      if (s_r.core.enActive && (!standbyMode || s_r.core.standbyRun))
      begin
         s_nxt.core.prescCnt = tick ? 10'h000 : s_r.core.prescCnt + 10'h001;
      end

      // Counter
      if (tick && s_r.core.running)
      begin
         if (wrap)
         begin
            s_nxt.core.count = s_r.core.dirDown ? periodValue : '0;
            if (s_r.core.singleRun)
            begin
               s_nxt.core.running = 1'b0;
            end
         end
         else if (s_r.core.dirDown)
         begin
            s_nxt.core.count = s_r.core.count - CNT_W'(1);
         end
         else
         begin
            s_nxt.core.count = s_r.core.count + CNT_W'(1);
         end
      end

      // Hardware update condition
      if (updCond)
      begin
         s_nxt.core.bufCopy = !s_r.core.updateLock || captureEn;
         s_nxt.core.frameCnt = (s_r.core.frameCnt + 6'h01) & dMask;
         s_nxt.core.dithExtra = (s_r.core.resol != pwt_pkg::DITH_NONE)
            && (((s_r.core.frameCnt + 6'h01) & dMask)
               < (periodValue[5:0] & dMask));
         if (dualRampMode)
         begin
            case (s_r.core.ramp_index_cmd)
               pwt_pkg::IDX_FORCE_B: s_nxt.core.cycleIdx = 1'b1;
               pwt_pkg::IDX_FORCE_A: s_nxt.core.cycleIdx = 1'b0;
               pwt_pkg::IDX_HOLD: s_nxt.core.cycleIdx = s_r.core.cycleIdx;
               default: s_nxt.core.cycleIdx = !s_r.core.cycleIdx;
            endcase
            s_nxt.core.ramp_index_cmd = pwt_pkg::IDX_TOGGLE;
         end
      end

      // Software command on the prescaled tick
      if (tick && (s_r.core.cmd != pwt_pkg::CMD_NONE))
      begin
         case (s_r.core.cmd)
            pwt_pkg::CMD_RETRIGGER:
            begin
               s_nxt.core.running = 1'b1;
               s_nxt.core.count = s_r.core.dirDown ? periodValue : '0;
            end
            pwt_pkg::CMD_STOP: s_nxt.core.running = 1'b0;
            pwt_pkg::CMD_UPDATE: s_nxt.core.bufCopy = 1'b1;
            pwt_pkg::CMD_COUNT_READ_SYNC_CMD: s_nxt.core.countSnap = s_r.core.count;
            default: s_nxt.core.cmd = pwt_pkg::CMD_NONE;
         endcase
         s_nxt.core.cmd = pwt_pkg::CMD_NONE;
      end

      // Crossing completes
      if (rstDone)
      begin
         s_nxt.core.enBusy = 1'b0;
         s_nxt.core.rstBusy = 1'b0;
         s_nxt.core.enActive = s_r.core.enableReq;
         if (s_r.core.rstBusy)
         begin
            s_nxt.core = '0;
         end
      end

      // Bus write address and data, taken in either order
      if (s_axi_awvalid && !s_r.awHeld && !s_r.bValid)
      begin
         s_nxt.awHeld = 1'b1;
         s_nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_r.wHeld && !s_r.bValid)
      begin
         s_nxt.wHeld = 1'b1;
         s_nxt.wData = s_axi_wdata;
         s_nxt.wStrb = s_axi_wstrb;
      end
      if (s_r.bValid && s_axi_bready)
      begin
         s_nxt.bValid = 1'b0;
      end

      // Register write; bus wins over same-cycle hardware clears
      if (doWrite)
      begin
         s_nxt.awHeld = 1'b0;
         s_nxt.wHeld = 1'b0;
         s_nxt.bValid = 1'b1;
         s_nxt.bResp = pwt_pkg::RESP_OKAY;
         if (s_r.awAddr[1:0] != 2'h0)
         begin
            s_nxt.bResp = pwt_pkg::RESP_SLVERR;
         end
         else if (idx == pwt_pkg::IDX_CTRL_A)
         begin
            if (s_r.wStrb[0] && wb[pwt_pkg::CA_SOFT_RESET])
            begin
               // Rest of this write is dropped
               s_nxt.core.softReset = 1'b1;
               s_nxt.core.rstBusy = 1'b1;
               s_nxt.core.syncCnt = 3'h0;
            end
            else
            begin
               if (s_r.wStrb[0])
               begin
                  s_nxt.core.resol = wb[pwt_pkg::CA_RESOL_LO +: 2];
                  s_nxt.core.enableReq = wb[pwt_pkg::CA_ENABLE];
                  s_nxt.core.enBusy = 1'b1;
                  s_nxt.core.syncCnt = 3'h0;
               end
               if (s_r.wStrb[1])
               begin
                  s_nxt.core.presc = s_r.wData[pwt_pkg::CA_PRESC_LO +: 3];
                  s_nxt.core.standbyRun = s_r.wData[pwt_pkg::CA_STDBY];
               end
            end
         end
         else if (idx == pwt_pkg::IDX_CTRL_B_CLR)
         begin
            if (s_r.wStrb[0])
            begin
               if (wb[pwt_pkg::CB_CMD_LO +: 3] != 3'h0)
               begin
                  s_nxt.core.cmd = pwt_pkg::CMD_NONE;
               end
               if (wb[pwt_pkg::CB_IDX_LO +: 2] != 2'h0)
               begin
                  s_nxt.core.ramp_index_cmd = pwt_pkg::IDX_TOGGLE;
               end
               if (wb[pwt_pkg::CB_SINGLE_RUN])
               begin
                  s_nxt.core.singleRun = 1'b0;
               end
               if (wb[pwt_pkg::CB_UPDATE_LOCK])
               begin
                  s_nxt.core.updateLock = 1'b0;
               end
               if (wb[pwt_pkg::CB_DIR])
               begin
                  s_nxt.core.dirDown = 1'b0;
               end
            end
         end
         else if (idx == pwt_pkg::IDX_CTRL_B_SET)
         begin
            if (s_r.wStrb[0])
            begin
               if (wb[pwt_pkg::CB_CMD_LO +: 3] != 3'h0)
               begin
                  s_nxt.core.cmd = wb[pwt_pkg::CB_CMD_LO +: 3];
               end
               if (wb[pwt_pkg::CB_IDX_LO +: 2] != 2'h0)
               begin
                  s_nxt.core.ramp_index_cmd = wb[pwt_pkg::CB_IDX_LO +: 2];
               end
               if (wb[pwt_pkg::CB_SINGLE_RUN])
               begin
                  s_nxt.core.singleRun = 1'b1;
               end
               if (wb[pwt_pkg::CB_UPDATE_LOCK])
               begin
                  s_nxt.core.updateLock = 1'b1;
               end
               if (wb[pwt_pkg::CB_DIR])
               begin
                  s_nxt.core.dirDown = 1'b1;
               end
            end
         end
         else if ((idx != pwt_pkg::IDX_SYNC_FLAGS)
            && (idx != pwt_pkg::IDX_COUNT_SNAP))
         begin
            s_nxt.bResp = pwt_pkg::RESP_SLVERR;
         end
      end

      // Bus read
      if (s_r.rValid && s_axi_rready)
      begin
         s_nxt.rValid = 1'b0;
      end
      if (s_axi_arvalid && !s_r.rValid)
      begin
         s_nxt.rValid = 1'b1;
         s_nxt.rResp = pwt_pkg::RESP_OKAY;
         s_nxt.rData = 32'h0000_0000;
         case (s_axi_araddr >> pwt_pkg::ADDR_SHIFT)
            pwt_pkg::IDX_CTRL_A:
            begin
               s_nxt.rData[pwt_pkg::CA_STDBY] = s_r.core.standbyRun;
               s_nxt.rData[pwt_pkg::CA_PRESC_LO +: 3] = s_r.core.presc;
               s_nxt.rData[pwt_pkg::CA_RESOL_LO +: 2] = s_r.core.resol;
               s_nxt.rData[pwt_pkg::CA_ENABLE] = s_r.core.enableReq;
               s_nxt.rData[pwt_pkg::CA_SOFT_RESET] = s_r.core.softReset;
            end
            pwt_pkg::IDX_CTRL_B_CLR: s_nxt.rData[7:0] = ctrlB;
            pwt_pkg::IDX_CTRL_B_SET: s_nxt.rData[7:0] = ctrlB;
            pwt_pkg::IDX_SYNC_FLAGS:
            begin
               s_nxt.rData[pwt_pkg::SB_SOFT_RESET] = s_r.core.rstBusy;
               s_nxt.rData[pwt_pkg::SB_ENABLE] = s_r.core.enBusy;
            end
            pwt_pkg::IDX_COUNT_SNAP:
            begin
               s_nxt.rData[CNT_W-1:0] = s_r.core.countSnap;
            end
            default: s_nxt.rResp = pwt_pkg::RESP_SLVERR;
         endcase
         if (s_axi_araddr[1:0] != 2'h0)
         begin
            s_nxt.rResp = pwt_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else if (clkEn)
      begin
         s_r <= s_nxt;
      end
   end

   // Checks
   logic swrstWrite;
   logic enWrite;
   assign swrstWrite = doWrite && s_r.wStrb[0]
      && (s_r.awAddr == (pwt_pkg::IDX_CTRL_A << pwt_pkg::ADDR_SHIFT))
      && s_r.wData[pwt_pkg::CA_SOFT_RESET];
   assign enWrite = doWrite && s_r.wStrb[0]
      && (s_r.awAddr == (pwt_pkg::IDX_CTRL_A << pwt_pkg::ADDR_SHIFT))
      && !s_r.wData[pwt_pkg::CA_SOFT_RESET];

   sequence seq_rst_pending;
      s_r.core.softReset && s_r.core.rstBusy;
   endsequence

   sequence seq_rst_cleared;
      !s_r.core.softReset && !s_r.core.rstBusy && !s_r.core.enActive;
   endsequence

   a_soft_reset_discard: assert property (@(posedge mclk) disable iff (rst)
      swrstWrite && clkEn |=> seq_rst_pending
         and (s_r.core.enableReq == $past(s_r.core.enableReq)))
      else $error("soft reset write kept other fields");

   a_soft_reset_finish: assert property (@(posedge mclk) disable iff (rst)
      (swrstWrite && clkEn) ##1 (clkEn[*3]) |=> seq_rst_cleared)
      else $error("soft reset did not complete");

   a_enable_readback: assert property (@(posedge mclk) disable iff (rst)
      enWrite && clkEn |=> s_r.core.enBusy
         && (s_r.core.enableReq == $past(s_r.wData[pwt_pkg::CA_ENABLE])))
      else $error("enable not read back with busy flag");

   a_enable_apply: assert property (@(posedge mclk) disable iff (rst)
      (enWrite && clkEn) ##1 (clkEn && !doWrite)[*3] |=>
         !s_r.core.enBusy && (s_r.core.enActive == s_r.core.enableReq))
      else $error("enable crossing did not finish");

   a_cmd_clear: assert property (@(posedge mclk) disable iff (rst)
      tick && clkEn && !doWrite && (s_r.core.cmd != pwt_pkg::CMD_NONE)
         |=> s_r.core.cmd == pwt_pkg::CMD_NONE)
      else $error("command not cleared after tick");

   a_lock_block: assert property (@(posedge mclk) disable iff (rst)
      updCond && clkEn && s_r.core.updateLock && !captureEn
         && (s_r.core.cmd != pwt_pkg::CMD_UPDATE) |=> !s_r.core.bufCopy)
      else $error("locked update copied buffers");

   a_unlock_copy: assert property (@(posedge mclk) disable iff (rst)
      updCond && clkEn && (!s_r.core.updateLock || captureEn)
         |=> s_r.core.bufCopy)
      else $error("unlocked update did not copy");

   a_single_stop: assert property (@(posedge mclk) disable iff (rst)
      updCond && clkEn && s_r.core.singleRun
         && (s_r.core.cmd != pwt_pkg::CMD_RETRIGGER) |=> !s_r.core.running)
      else $error("single run kept counting");

   a_count_step: assert property (@(posedge mclk) disable iff (rst)
      tick && clkEn && s_r.core.running && !wrap
         && (s_r.core.cmd != pwt_pkg::CMD_RETRIGGER)
         |=> s_r.core.count == ($past(s_r.core.count)
            + ($past(s_r.core.dirDown) ? {CNT_W{1'b1}} : CNT_W'(1))))
      else $error("counter stepped wrong way");

   a_standby_halt: assert property (@(posedge mclk) disable iff (rst)
      standbyMode && !s_r.core.standbyRun |-> !tick)
      else $error("counter ticked in standby");

endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the PWM timer control block.
// Assumes one clock, mclk, for both the AXI4-Lite slave and the counter.
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic clkEn = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic standbyMode = 1'b0, captureEn = 1'b0, dualRampMode = 1'b0;
   logic [23:0] periodValue = 24'hffffff;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, countDown, counterRunning, counterEnabled;
   logic bufferCopy, cycleIndexFlag, ditherExtra;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] s_axi_rdata, rv;
   logic [23:0] count;
   int fail_count = 0;
   int n_checks = 0;
   int i, g, p;
   int dv[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};

   pwt_timer_ctrl #(.CNT_W(24)) uut (.mclk, .rst, .clkEn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .standbyMode, .captureEn, .dualRampMode, .periodValue, .count,
      .countDown, .counterRunning, .counterEnabled, .bufferCopy,
      .cycleIndexFlag, .ditherExtra);

   initial
      forever #12.5 mclk = ~mclk;

   task automatic final_report();
      if (fail_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got,
                      input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic hang(input logic ok);
      if (!ok)
      begin
         fail_count++;
         final_report();
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // Ready is combinational on state, so its negedge value holds at posedge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ah, wh, bh;
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      bh = 1'b0;
      for (n = 0; n < 50 && !bh; n++)
      begin
         @(negedge mclk);
         ah = s_axi_awvalid && s_axi_awready;
         wh = s_axi_wvalid && s_axi_wready;
         bh = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge mclk);
         if (ah)
            s_axi_awvalid <= 1'b0;
         if (wh)
            s_axi_wvalid <= 1'b0;
      end
      hang(bh);
      s_axi_bready <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] a);
      logic ah, rh;
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rh = 1'b0;
      for (n = 0; n < 50 && !rh; n++)
      begin
         @(negedge mclk);
         ah = s_axi_arvalid && s_axi_arready;
         rh = s_axi_rvalid;
         rv = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge mclk);
         if (ah)
            s_axi_arvalid <= 1'b0;
      end
      hang(rh);
      s_axi_rready <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk($sformatf("reg %h", a), rv, exp);
   endtask

   // Cycles between two successive counter steps
   task automatic gap(output int gl);
      logic [23:0] c;
      int n;
      @(negedge mclk);
      c = count;
      for (n = 0; n < 2100 && count === c; n++)
         @(negedge mclk);
      c = count;
      for (gl = 0; gl < 2100 && count === c; gl++)
         @(negedge mclk);
      @(posedge mclk);
   endtask

   task automatic pulses(input int len, output int pc);
      pc = 0;
      repeat (len)
      begin
         @(negedge mclk);
         pc += int'(bufferCopy === 1'b1);
      end
      @(posedge mclk);
   endtask

   task automatic port(input string nm, input logic got, input logic exp);
      chk(nm, {31'h0, got}, {31'h0, exp});
   endtask

   initial
   begin
      cyc(20);
      rst <= 1'b0;
      cyc(1);
      rc(8'h00, 32'h0);
      rc(8'h10, 32'h0);
      rc(8'h14, 32'h0);
      rc(8'h20, 32'h0);
      rd(8'h44);
      chk("unmapped rresp", rs, pwt_pkg::RESP_SLVERR);
      wr(8'h44, 32'h1);
      chk("unmapped bresp", rs, pwt_pkg::RESP_SLVERR);
      wr(8'h00, 32'h2);
      rc(8'h00, 32'h2);
      cyc(10);
      @(negedge mclk);
      port("enabled", counterEnabled, 1'b1);
      @(posedge mclk);
      rc(8'h20, 32'h0);
      wr(8'h14, 32'h20);
      rc(8'h14, 32'h0);
      @(negedge mclk);
      port("running", counterRunning, 1'b1);
      @(posedge mclk);
      for (i = 0; i < 8; i++)
      begin
         wr(8'h00, {21'h0, i[2:0], 8'h02});
         gap(g);
         chk("prescaler gap", g, dv[i]);
      end
      wr(8'h00, 32'h2);
      standbyMode <= 1'b1;
      gap(g);
      chk("standby halt", g, 2100);
      wr(8'h00, 32'h0802);
      gap(g);
      chk("standby run", g, 1);
      standbyMode <= 1'b0;
      wr(8'h14, 32'h01);
      rc(8'h10, 32'h01);
      wr(8'h10, 32'h00);
      rc(8'h14, 32'h01);
      @(negedge mclk);
      port("down", countDown, 1'b1);
      @(posedge mclk);
      wr(8'h10, 32'h01);
      rc(8'h14, 32'h00);
      @(negedge mclk);
      port("up", countDown, 1'b0);
      @(posedge mclk);
      wr(8'h14, 32'h04);
      rc(8'h10, 32'h04);
      wr(8'h10, 32'h00);
      rc(8'h14, 32'h04);
      wr(8'h10, 32'h04);
      rc(8'h14, 32'h00);
      periodValue <= 24'h000007;
      wr(8'h14, 32'h20);
      pulses(64, p);
      chk("copies free", p, 8);
      wr(8'h14, 32'h02);
      pulses(64, p);
      chk("copies locked", p, 0);
      captureEn <= 1'b1;
      pulses(64, p);
      chk("copies capture", p, 8);
      captureEn <= 1'b0;
      fork
         wr(8'h14, 32'h62);
         pulses(64, p);
      join
      chk("forced copy", p, 1);
      wr(8'h10, 32'h02);
      rc(8'h14, 32'h00);
      pulses(64, p);
      chk("copies unlocked", p, 8);
      dualRampMode <= 1'b1;
      for (i = 1; i < 3; i++)
      begin
         wr(8'h14, {27'h0, i[1:0], 3'h0});
         cyc(20);
         rc(8'h14, 32'h0);
         @(negedge mclk);
         port("cycle index", cycleIndexFlag, i == 1);
         @(posedge mclk);
      end
      dualRampMode <= 1'b0;
      wr(8'h14, 32'h80);
      rc(8'h14, 32'h0);
      rd(8'h3c);
      chk("snapshot range", {31'h0, rv <= 32'h7}, 32'h1);
      wr(8'h14, 32'h40);
      cyc(4);
      @(negedge mclk);
      port("stopped", counterRunning, 1'b0);
      @(posedge mclk);
      wr(8'h14, 32'h20);
      wr(8'h00, 32'h0702);
      wr(8'h14, 32'h40);
      wr(8'h10, 32'he0);
      rc(8'h14, 32'h0);
      @(negedge mclk);
      port("stop cancelled", counterRunning, 1'b1);
      @(posedge mclk);
      wr(8'h00, 32'h0022);
      cyc(8);
      // Period low bits 7: seven of every sixteen frames stretched
      p = 0;
      repeat (128)
      begin
         @(negedge mclk);
         p += int'(ditherExtra === 1'b1);
      end
      @(posedge mclk);
      chk("dither frames", p, 56);
      wr(8'h14, 32'h04);
      cyc(30);
      @(negedge mclk);
      port("single run", counterRunning, 1'b0);
      @(posedge mclk);
      wr(8'h14, 32'h03);
      wr(8'h00, 32'h0f63);
      rc(8'h00, 32'h23);
      cyc(10);
      rc(8'h00, 32'h0);
      rc(8'h14, 32'h0);
      rc(8'h20, 32'h0);
      @(negedge mclk);
      port("reset disables", counterEnabled, 1'b0);
      port("reset direction", countDown, 1'b0);
      @(posedge mclk);
      final_report();
   end
endmodule
